// ===== sct_core_timing.v
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
// What this block does
// - one-cycle op: strobe high first half
// - multi-cycle op: strobe high first half only
// - back-to-back single ops give one strobe pulse per op
// - timer advances every core clock
// - no external code fetch bus cycles
// - movx stretched by programmed wait count
// - movx takes four plus n cycles
// - interrupt lcall takes three cycles
// - bit access only at addresses ending 0/8
// - keep clock counters across reset if enabled
// - most ops one or two machine cycles
// - register arithmetic one byte one cycle
// - indirect arithmetic one byte two cycles
// - direct arithmetic two bytes two cycles
// - add immediate two bytes two cycles
// - subb immediate one byte one cycle
`include "sct_regs.vh"
module sct_core_timing #(
    parameter [7:0] IDENT_CODE = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // axi4-lite write address and data
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // external bus strobes
    output reg ale_ff,
    output reg xdata_rd_ff,
    output reg code_fetch_ext_ff,
    output reg busy_ff
);
    // instruction classes for the exec register
    localparam [3:0] OP_REG = 4'h0;
    localparam [3:0] OP_IND = 4'h1;
    localparam [3:0] OP_DIR = 4'h2;
    localparam [3:0] OP_ADDI = 4'h3;
    localparam [3:0] OP_SUBBI = 4'h4;
    localparam [3:0] OP_MOVX = 4'h5;
    localparam [3:0] OP_LCALL = 4'h6;
    localparam [3:0] OP_LCALLI = 4'h7;
    localparam [3:0] OP_MUL = 4'h8;
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg [7:0] spl_ff;
    reg [7:0] dpl_ff;
    reg [7:0] dph_ff;
    reg [7:0] dpp_ff;
    reg [7:0] power_control_ff;
    reg [7:0] dual_pointer_control_ff;
    reg [7:0] cfg_ff;
    reg [7:0] sph_ff;
    reg [7:0] tkctl_ff;
    reg [7:0] hund_ff;
    reg [7:0] sec_ff;
    reg [7:0] min_ff;
    reg [7:0] hours_counter_ff;
    reg [7:0] wait_ff;
    reg [7:0] clkdiv_ff;
    reg [15:0] tmr_ff;
    reg [7:0] cyc_left_ff;
    reg [7:0] last_cyc_ff;
    reg [7:0] last_len_ff;
    reg half_ff;
    reg state_ff;
    reg bit_err_ff;
    reg [11:0] awaddr_ff;
    reg [11:0] araddr_ff;
    reg aw_ok_ff;
    reg w_ok_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg [7:0] nxt_cyc;
    reg [7:0] nxt_len;
    reg [31:0] rd_word;
    reg rd_hit;
    reg wr_hit;
    // pending read flag: one cycle lets araddr_ff settle before the mux
    reg rd_pend_ff;
    wire [7:0] wr_idx = awaddr_ff[9:2];
    wire [7:0] rd_idx = araddr_ff[9:2];
    wire wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
    wire wr_b0 = wr_go && wstrb_ff[0];
    wire start = wr_b0 && wr_idx == `SCT_REG_EXEC && state_ff == ST_IDLE;
    wire [3:0] op = wdata_ff[3:0];

    // cycle and length per class
    always @* begin
        nxt_cyc = 8'h01;
        nxt_len = 8'h01;
        case (op)
            OP_REG: begin
                nxt_cyc = 8'h01;
                nxt_len = 8'h01;
            end
            OP_IND: begin
                nxt_cyc = 8'h02;
                nxt_len = 8'h01;
            end
            OP_DIR: begin
                nxt_cyc = 8'h02;
                nxt_len = 8'h02;
            end
            OP_ADDI: begin
                nxt_cyc = 8'h02;
                nxt_len = 8'h02;
            end
            OP_SUBBI: begin
                nxt_cyc = 8'h01;
                nxt_len = 8'h01;
            end
            OP_MOVX: begin
                nxt_cyc = 8'd`SCT_CYC_MOVX + wait_ff;
                nxt_len = 8'h01;
            end
            OP_LCALL: begin
                nxt_cyc = 8'd`SCT_CYC_LCALL;
                nxt_len = 8'h03;
            end
            OP_LCALLI: begin
                nxt_cyc = 8'd`SCT_CYC_LCALL_IRQ;
                nxt_len = 8'h03;
            end
            OP_MUL: begin
                nxt_cyc = 8'h09;
                nxt_len = 8'h01;
            end
            default: begin
                nxt_cyc = 8'h01;
                nxt_len = 8'h01;
            end
        endcase
    end

    // sequencer: each machine cycle is two half phases of sys_clk
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            half_ff <= 1'b0;
            cyc_left_ff <= 8'h00;
            last_cyc_ff <= 8'h00;
            last_len_ff <= 8'h00;
            ale_ff <= 1'b0;
            xdata_rd_ff <= 1'b0;
            busy_ff <= 1'b0;
            code_fetch_ext_ff <= 1'b0;
        end else begin
            code_fetch_ext_ff <= 1'b0; // code is internal only
            case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        state_ff <= ST_RUN;
                        half_ff <= 1'b1;
                        cyc_left_ff <= nxt_cyc;
                        last_cyc_ff <= nxt_cyc;
                        last_len_ff <= nxt_len;
                        ale_ff <= 1'b1; // first half of first cycle
                        busy_ff <= 1'b1;
                        xdata_rd_ff <= (op == OP_MOVX);
                    end
                end
                ST_RUN: begin
                    half_ff <= ~half_ff;
                    // strobe low for rest of op
                    ale_ff <= 1'b0;
                    if (!half_ff) begin
                        if (cyc_left_ff == 8'h01) begin
                            state_ff <= ST_IDLE;
                            busy_ff <= 1'b0;
                            xdata_rd_ff <= 1'b0;
                        end
                        cyc_left_ff <= cyc_left_ff - 8'h01;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
    // back-to-back single ops give one strobe pulse per op

    // timer counts every core clock, not every twelve
    always @(posedge sys_clk) begin
        if (sys_rst)
            tmr_ff <= 16'h0000;
        else
            tmr_ff <= tmr_ff + 16'h0001;
    end

    // axi write channel capture
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awready && s_axi_awvalid) begin
                aw_ok_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_ok_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
            end
        end
    end

    // write decode
    always @* begin
        case (wr_idx)
            `SCT_SFR_SPL, `SCT_SFR_DPL, `SCT_SFR_DPH, `SCT_SFR_DPP,
            `SCT_SFR_POWER_CONTROL, `SCT_SFR_DUAL_POINTER_CONTROL, `SCT_SFR_CFG, `SCT_SFR_SPH,
            `SCT_SFR_TKCTL, `SCT_SFR_HUND, `SCT_SFR_SEC, `SCT_SFR_MIN,
            `SCT_SFR_HOURS_COUNTER, `SCT_SFR_WAIT, `SCT_SFR_CLKDIV, `SCT_REG_EXEC,
            `SCT_REG_BITOP: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // bit op word: [7:0] sfr address, [10:8] bit, [11] value
    wire bit_ok = (wdata_ff[3:0] == 4'h0) || (wdata_ff[3:0] == 4'h8);
    wire bit_go = wr_b0 && wr_idx == `SCT_REG_BITOP && bit_ok;
    wire [7:0] bmask = 8'h01 << wdata_ff[10:8];
    wire [7:0] wb = wdata_ff[7:0];

    // sfr storage
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            spl_ff <= `SCT_RST_SPL;
            dpl_ff <= 8'h00;
            dph_ff <= 8'h00;
            dpp_ff <= 8'h00;
            power_control_ff <= 8'h00;
            dual_pointer_control_ff <= 8'h00;
            cfg_ff <= 8'h00;
            sph_ff <= 8'h00;
            wait_ff <= 8'h00;
            clkdiv_ff <= `SCT_RST_CLKDIV;
            bit_err_ff <= 1'b0;
            // keep time of day when retention set
            if (!tkctl_ff[`SCT_TK_KEEP_BIT]) begin
                hund_ff <= 8'h00;
                sec_ff <= 8'h00;
                min_ff <= 8'h00;
                hours_counter_ff <= 8'h00;
                tkctl_ff <= 8'h00;
            end
        end else begin
            if (wr_b0 && wr_idx == `SCT_REG_BITOP)
                bit_err_ff <= !bit_ok; // byte-only sfr refused
            if (bit_go && wdata_ff[7:0] == `SCT_SFR_POWER_CONTROL)
                power_control_ff <= wdata_ff[11] ? (power_control_ff | bmask)
                                        : (power_control_ff & ~bmask);
            if (wr_b0) begin
                case (wr_idx)
                    `SCT_SFR_SPL: spl_ff <= wb;
                    `SCT_SFR_DPL: dpl_ff <= wb;
                    `SCT_SFR_DPH: dph_ff <= wb;
                    `SCT_SFR_DPP: dpp_ff <= wb;
                    `SCT_SFR_POWER_CONTROL: power_control_ff <= wb;
                    `SCT_SFR_DUAL_POINTER_CONTROL: dual_pointer_control_ff <= wb;
                    `SCT_SFR_CFG: cfg_ff <= wb;
                    `SCT_SFR_SPH: sph_ff <= wb;
                    `SCT_SFR_TKCTL: tkctl_ff <= wb;
                    `SCT_SFR_HUND: hund_ff <= wb;
                    `SCT_SFR_SEC: sec_ff <= wb;
                    `SCT_SFR_MIN: min_ff <= wb;
                    `SCT_SFR_HOURS_COUNTER: hours_counter_ff <= wb;
                    `SCT_SFR_WAIT: wait_ff <= wb;
                    `SCT_SFR_CLKDIV: clkdiv_ff <= wb;
                    default: ;
                endcase
            end
        end
    end

    // read mux; unmapped answers slverr with zero data
    always @* begin
        rd_hit = 1'b1;
        rd_word = 32'h00000000;
        case (rd_idx)
            `SCT_SFR_SPL: rd_word[7:0] = spl_ff;
            `SCT_SFR_DPL: rd_word[7:0] = dpl_ff;
            `SCT_SFR_DPH: rd_word[7:0] = dph_ff;
            `SCT_SFR_DPP: rd_word[7:0] = dpp_ff;
            `SCT_SFR_POWER_CONTROL: rd_word[7:0] = power_control_ff;
            `SCT_SFR_DUAL_POINTER_CONTROL: rd_word[7:0] = dual_pointer_control_ff;
            `SCT_SFR_CFG: rd_word[7:0] = cfg_ff;
            `SCT_SFR_SPH: rd_word[7:0] = sph_ff;
            `SCT_SFR_TKCTL: rd_word[7:0] = tkctl_ff;
            `SCT_SFR_HUND: rd_word[7:0] = hund_ff;
            `SCT_SFR_SEC: rd_word[7:0] = sec_ff;
            `SCT_SFR_MIN: rd_word[7:0] = min_ff;
            `SCT_SFR_HOURS_COUNTER: rd_word[7:0] = hours_counter_ff;
            `SCT_SFR_WAIT: rd_word[7:0] = wait_ff;
            `SCT_SFR_CLKDIV: rd_word[7:0] = clkdiv_ff;
            `SCT_SFR_TMRL: rd_word[7:0] = tmr_ff[7:0];
            `SCT_SFR_TMRH: rd_word[7:0] = tmr_ff[15:8];
            `SCT_SFR_IDENT: rd_word[7:0] = IDENT_CODE;
            `SCT_REG_STAT: rd_word = {8'h00, last_len_ff, last_cyc_ff,
                                      5'h00, bit_err_ff, state_ff, busy_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    // axi read channel: answer two cycles after address is taken
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
            araddr_ff <= 12'h000;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                             s_axi_arvalid;
            if (s_axi_arready && s_axi_arvalid)
                araddr_ff <= s_axi_araddr;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            else if (rd_pend_ff) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
            end
        end
    end

    // read accepted last edge; data goes out on the next
    always @(posedge sys_clk) begin
        if (sys_rst)
            rd_pend_ff <= 1'b0;
        else
            rd_pend_ff <= s_axi_arready && s_axi_arvalid;
    end
endmodule // sct_core_timing

// ===== sct_regs.vh
`ifndef SCT_REGS_VH
`define SCT_REGS_VH
// sfr byte offsets (index form, byte address is four times)
`define SCT_SFR_SPL 8'h81
`define SCT_SFR_DPL 8'h82
`define SCT_SFR_DPH 8'h83
`define SCT_SFR_DPP 8'h84
`define SCT_SFR_POWER_CONTROL 8'h87
`define SCT_SFR_DUAL_POINTER_CONTROL 8'hA7
`define SCT_SFR_CFG 8'hAF
`define SCT_SFR_SPH 8'hB7
`define SCT_SFR_TKCTL 8'hA1
`define SCT_SFR_HUND 8'hA2
`define SCT_SFR_SEC 8'hA3
`define SCT_SFR_MIN 8'hA4
`define SCT_SFR_HOURS_COUNTER 8'hA5
`define SCT_SFR_WAIT 8'h9F
`define SCT_SFR_CLKDIV 8'hD7
`define SCT_SFR_TMRL 8'h8A
`define SCT_SFR_TMRH 8'h8C
`define SCT_SFR_IDENT 8'hC2
// block-private registers
`define SCT_REG_EXEC 8'hF0
`define SCT_REG_STAT 8'hF1
`define SCT_REG_BITOP 8'hF2
// reset values
`define SCT_RST_SPL 8'h07
`define SCT_RST_CLKDIV 8'h03
// field positions
`define SCT_TK_KEEP_BIT 0
// cycle counts
`define SCT_CYC_MOVX 4
`define SCT_CYC_LCALL_IRQ 3
`define SCT_CYC_LCALL 4
`endif

// ===== sct_core_timing_monitor.sv
`timescale 1ns/10ps
module sct_core_timing_monitor (
    // clock and reset
    input logic sys_clk,
    input logic sys_rst,
    // bus handshakes
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // core strobes
    input logic ale_ff,
    input logic xdata_rd_ff,
    input logic code_fetch_ext_ff,
    input logic busy_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // both write channels taken on one edge, as the walk shows
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_no_ext_fetch: assert property (!code_fetch_ext_ff)
        else $error("external code fetch strobe seen");
    a_ale_first_half: assert property ($rose(ale_ff) |=> !ale_ff)
        else $error("latch strobe high past first half");
    a_ale_opens_op: assert property ($rose(busy_ff) |->
        $past(ale_ff) or ##[0:1] ale_ff)
        else $error("op started without latch strobe");
    a_ale_in_op: assert property (ale_ff |-> ##[0:1] busy_ff)
        else $error("latch strobe outside an op");
    a_xrd_in_op: assert property (xdata_rd_ff |->
        busy_ff || $past(busy_ff))
        else $error("xdata read strobe outside an op");
    a_bresp_latency: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rresp_latency: assert property (ar_taken |-> ##2 s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid)
        else $error("write response dropped before bready");
endmodule // sct_core_timing_monitor

bind sct_core_timing sct_core_timing_monitor sct_core_timing_monitor_inst (
    .sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .ale_ff, .xdata_rd_ff, .code_fetch_ext_ff, .busy_ff);

// ===== sct_xram_model.sv
`timescale 1ns/10ps
module sct_xram_model (
    // clock and reset
    input logic sys_clk,
    input logic sys_rst,
    // read strobe from the core
    input logic xdata_rd_ff,
    // accesses seen
    output int reads
);
    logic last_ff = 1'b0;
    initial reads = 0;
    // count kept through reset so the bench can diff across it
    always @(posedge sys_clk) begin
        last_ff <= xdata_rd_ff;
        if (xdata_rd_ff && !last_ff) reads <= reads + 1;
    end
endmodule // sct_xram_model

// ===== tb_single_cycle_core_timing.sv
`timescale 1ns/10ps
`include "sct_regs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", nm, e, g); \
    end end
module tb_single_cycle_core_timing;
    logic sys_clk = 0, sys_rst = 1;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rd;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, ale_ff, xdata_rd_ff, code_fetch_ext_ff, busy_ff;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    logic [1:0] rr;
    logic [7:0] v, wn;
    logic [7:0] ridx [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h87, 8'hA7,
        8'hAF, 8'hB7, 8'hD7, 8'hC2};
    logic [7:0] rval [10] = '{8'h07, 0, 0, 0, 0, 0, 0, 0, 8'h03, 8'h5A};
    int num_errors = 0, samples_checked = 0, cyc = 0, rcyc, t0, reads, x0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    // all byte lanes offered; only the lane 0 strobe is decoded
    sct_core_timing sct_core_timing_inst (.sys_clk, .sys_rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ale_ff, .xdata_rd_ff, .code_fetch_ext_ff, .busy_ff);
    sct_xram_model sct_xram_model_inst (.sys_clk, .sys_rst, .xdata_rd_ff,
        .reads);
    // write one word, each channel released when taken
    task automatic axw(input [7:0] idx, input [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) num_errors++;
    endtask
    task automatic axr(input [7:0] idx);
        int n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        rcyc = cyc;
        s_axi_rready <= 1'b0;
        if (n >= 50) num_errors++;
    endtask
    task automatic rst5();
        sys_rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask
    // launch an op class, let it drain, then fetch status
    task automatic run_op(input [3:0] c);
        int n = 0;
        axw(8'hF0, c);
        repeat (3) @(posedge sys_clk);
        while (busy_ff !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        axr(8'hF1);
    endtask
    function automatic [7:0] exp_cyc(input [3:0] c, input [7:0] n);
        case (c)
            1, 2, 3: exp_cyc = 2;
            5: exp_cyc = 4 + n;
            6: exp_cyc = 4;
            7: exp_cyc = 3;
            8: exp_cyc = 9;
            default: exp_cyc = 1;
        endcase
    endfunction
    // zero marks a length the table leaves open
    function automatic [7:0] exp_byt(input [3:0] c);
        case (c)
            0, 1, 4, 8: exp_byt = 1;
            2, 3: exp_byt = 2;
            6: exp_byt = 3;
            default: exp_byt = 0;
        endcase
    endfunction
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // cut a hang short well past the expected run length
    initial begin
        #500000;
        num_errors++;
        final_report();
    end
    initial begin
        v = $urandom(34000);
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            axr(ridx[i]);
            `CHK("reset value", rval[i], rd[7:0])
        end
        axr(8'h90);
        `CHK("unmapped resp", 2'b10, rr)
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            axw(ridx[i == 4 ? 1 : i], v);
            axr(ridx[i == 4 ? 1 : i]);
            `CHK("readback", v, rd[7:0])
        end
        axr(8'h8A);
        t0 = rcyc;
        v = rd[7:0];
        axr(8'h8A);
        `CHK("timer step", 8'(rcyc - t0), 8'(rd[7:0] - v))
        axw(8'h9F, 0);
        for (int c = 0; c < 9; c++) begin
            run_op(c);
            `CHK("op cycles", exp_cyc(c, 0), rd[15:8])
            if (exp_byt(c) != 0)
                `CHK("op bytes", exp_byt(c), rd[23:16])
        end
        for (int k = 0; k < 3; k++) begin
            wn = k == 0 ? 0 : k == 1 ? 7 : $urandom % 8;
            axw(8'h9F, wn);
            x0 = reads;
            run_op(5);
            `CHK("movx cycles", exp_cyc(5, wn), rd[15:8])
            `CHK("movx reads", 1, reads - x0)
        end
        axw(8'h87, 8'h0C);
        axw(8'hF2, {20'h0, 1'b1, 3'd0, 8'h87});
        axr(8'hF1);
        `CHK("bit error", 1'b1, rd[2])
        axw(8'hF2, {20'h0, 1'b1, 3'd0, 8'h88});
        axr(8'hF1);
        `CHK("bit accepted", 1'b0, rd[2])
        axr(8'h87);
        `CHK("bit ignored", 8'h0C, rd[7:0])
        v = $urandom % 100;
        axw(8'hA1, 1);
        axw(8'hA2, v);
        rst5();
        axr(8'hA2);
        `CHK("kept count", v, rd[7:0])
        axw(8'hA1, 0);
        axw(8'hA2, v | 8'h01);
        rst5();
        axr(8'hA2);
        `CHK("cleared count", 8'h00, rd[7:0])
        final_report();
    end
endmodule // tb_single_cycle_core_timing
